/* lpsc_defs.vh */
// constants for the low-power state control block
`ifndef LPSC_DEFS_VH
`define LPSC_DEFS_VH

// one-hot state codes
`define LPSC_ST_W 3
`define LPSC_ST_RUN 3'h1
`define LPSC_ST_GRANT 3'h2
`define LPSC_ST_SLEEP 3'h4
// synchroniser depth for pin inputs
`define LPSC_SYNC_W 3
// synchroniser reset pattern and the idle level of the request pins
`define LPSC_SYNC_RST 3'h7
`define LPSC_PIN_IDLE 1'h1

`endif

/* lpsc_sync.v */
// three-stage synchroniser with agreement filter for one pin input
`include "lpsc_defs.vh"

module lpsc_sync (
    clk,
    resetn,
    pin_in,
    level_out
);
    input wire clk;
    input wire resetn;
    input wire pin_in;
    output reg level_out;

    reg [`LPSC_SYNC_W-1:0] stage_r;

    ////////////////////////////////////////////////////////////////////////
    // pins idle high (inactive) at reset; level changes when stages 2 and 3
    // agree, stage 1 is read only by stage 2
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage_r <= `LPSC_SYNC_RST;
            level_out <= `LPSC_PIN_IDLE;
        end else begin
            stage_r <= {stage_r[`LPSC_SYNC_W-2:0], pin_in};
            if (stage_r[1] == stage_r[2])
                level_out <= stage_r[2];
        end
    end
endmodule // lpsc_sync

/* lpsc_ctrl.v */
// low-power state control: halt grant and sleep states, clock gating
`include "lpsc_defs.vh"

module lpsc_ctrl (
    clk,
    resetn,
    clock_halt_request_n,
    sleep_request_n,
    bus_clk_present,
    intr_req,
    snoop_req,
    grant_ack_done,
    grant_ack_req,
    core_clk_en,
    bus_unit_clk_en,
    pll_run,
    exec_en,
    intr_take,
    snoop_take,
    halt_granted,
    asleep
);
    // clock and reset; clk is the bus clock and nothing here gates it
    input wire clk;
    input wire resetn;
    // request pins from the chipset, active low, asynchronous to clk
    input wire clock_halt_request_n;
    input wire sleep_request_n;
    // same-domain status and event inputs
    input wire bus_clk_present;
    input wire intr_req;
    input wire snoop_req;
    input wire grant_ack_done;
    // registered acknowledge request and internal clock enables; pll_run is a wire tied high
    output reg grant_ack_req;
    output reg core_clk_en;
    output reg bus_unit_clk_en;
    output wire pll_run;
    output reg exec_en;
    // acceptance strobes and state flags
    output wire intr_take;
    output wire snoop_take;
    output wire halt_granted;
    output wire asleep;

    ////////////////////////////////////////////////////////////////////////
    // one-hot state codes, local names for the shared constants
    localparam [`LPSC_ST_W-1:0] ST_RUN = `LPSC_ST_RUN;
    localparam [`LPSC_ST_W-1:0] ST_GRANT = `LPSC_ST_GRANT;
    localparam [`LPSC_ST_W-1:0] ST_SLEEP = `LPSC_ST_SLEEP;

    // state register and its next value
    reg [`LPSC_ST_W-1:0] state_r;
    reg [`LPSC_ST_W-1:0] state_nxt;
    // next values of the registered outputs
    reg ack_pend_nxt;
    reg core_clk_nxt;
    reg bus_unit_clk_nxt;
    reg exec_nxt;
    // synchronised request levels, still active low
    wire halt_req_sync_n;
    wire sleep_req_sync_n;
    // decoded present state
    wire in_run;
    wire in_grant;
    wire in_sleep;
    // transition and wake events
    wire grant_entry;
    wire bus_clk_lost;

    ////////////////////////////////////////////////////////////////////////
    // state decode; each test is needed by several processes below
    function st_is_run;
        input [`LPSC_ST_W-1:0] st;
        begin
            st_is_run = (st == ST_RUN);
        end
    endfunction

    function st_is_grant;
        input [`LPSC_ST_W-1:0] st;
        begin
            st_is_grant = (st == ST_GRANT);
        end
    endfunction

    function st_is_sleep;
        input [`LPSC_ST_W-1:0] st;
        begin
            st_is_sleep = (st == ST_SLEEP);
        end
    endfunction

    // core units run, and instructions execute, only in run
    function st_core_on;
        input [`LPSC_ST_W-1:0] st;
        begin
            st_core_on = st_is_run(st);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // both requests arrive from the chipset without regard to our clock;
    // the filter costs four edges of latency but keeps a runt pulse on a
    // pin from moving the state machine
    lpsc_sync u_halt_sync (
        .clk(clk),
        .resetn(resetn),
        .pin_in(clock_halt_request_n),
        .level_out(halt_req_sync_n)
    );

    // the sleep pin is just as asynchronous and gets the same treatment
    lpsc_sync u_sleep_sync (
        .clk(clk),
        .resetn(resetn),
        .pin_in(sleep_request_n),
        .level_out(sleep_req_sync_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // present state flags
    assign in_run = st_is_run(state_r);
    assign in_grant = st_is_grant(state_r);
    assign in_sleep = st_is_sleep(state_r);
    // only a move from run into grant starts an acknowledge
    assign grant_entry = in_run && st_is_grant(state_nxt);
    // bus clock removal comes in as a same-domain level from its monitor
    assign bus_clk_lost = !bus_clk_present;

    ////////////////////////////////////////////////////////////////////////
    // next state; run -> grant -> sleep -> grant -> run, nothing skips
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                // a sleep request here is refused and leaves no trace
                if (!halt_req_sync_n) begin
                    state_nxt = ST_GRANT;
                end
            end
            ST_GRANT: begin
                // sleep is reachable only from here and wins over release
                if (!sleep_req_sync_n) begin
                    state_nxt = ST_SLEEP;
                end else if (halt_req_sync_n) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_SLEEP: begin
                // halt release, snoops and interrupts are not looked at;
                // reset acts through the asynchronous branch below
                if (sleep_req_sync_n || bus_clk_lost) begin
                    state_nxt = ST_GRANT;
                end
            end
            default: begin
                // an illegal code falls back to run with clocks on
                state_nxt = ST_RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // acknowledge request: raised on entry from run, held until the bus
    // unit reports it done or the next state is run; entry is applied after done so that a new
    // request in the same cycle is not lost; a return from sleep does not
    // repeat it, the grant was already acknowledged
    always @* begin
        ack_pend_nxt = grant_ack_req;
        if (grant_ack_done) begin
            ack_pend_nxt = 1'b0;
        end
        if (grant_entry) begin
            ack_pend_nxt = 1'b1;
        end
        if (st_is_run(state_nxt)) begin
            ack_pend_nxt = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock enables for the next cycle; the core and execution stop in
    // grant and sleep, the bus unit keeps its clock in grant so that the
    // acknowledge can go out, and loses it only in sleep
    always @* begin
        core_clk_nxt = st_core_on(state_nxt);
        exec_nxt = st_core_on(state_nxt);
        bus_unit_clk_nxt = !st_is_sleep(state_nxt);
    end

    ////////////////////////////////////////////////////////////////////////
    // state and registered outputs; enables come from the next state so
    // they switch on the same edge as the state register
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // reset returns to run with every clock running
            state_r <= ST_RUN;
            grant_ack_req <= 1'b0;
            core_clk_en <= 1'b1;
            bus_unit_clk_en <= 1'b1;
            exec_en <= 1'b1;
        end else begin
            // normal operation follows the next-state logic
            state_r <= state_nxt;
            grant_ack_req <= ack_pend_nxt;
            core_clk_en <= core_clk_nxt;
            bus_unit_clk_en <= bus_unit_clk_nxt;
            exec_en <= exec_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // the pll keeps running in every state, sleep included
    assign pll_run = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // interrupts are serviced in run and grant and dropped while asleep;
    // nothing is latched, a source that wants service must hold its level
    assign intr_take = intr_req && !in_sleep;
    assign snoop_take = snoop_req && !in_sleep;
    // state flags straight from the state register
    assign halt_granted = in_grant;
    assign asleep = in_sleep;
endmodule // lpsc_ctrl

/* lpsc_ctrl_assertions.sv */
// assertions on the low-power state control ports
module lpsc_chk (
    input wire clk,
    input wire resetn,
    input wire clock_halt_request_n,
    input wire sleep_request_n,
    input wire grant_ack_req,
    input wire core_clk_en,
    input wire bus_unit_clk_en,
    input wire pll_run,
    input wire halt_granted,
    input wire asleep
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // pins cross a synchroniser, so answers take 3 to 6 edges
    sequence s_on; ##[3:6] halt_granted; endsequence
    sequence s_up; ##[3:6] (halt_granted && bus_unit_clk_en); endsequence
    property p_on; $fell(clock_halt_request_n) && !asleep |-> s_on; endproperty
    a_on: assert property (p_on) else $error("no grant");
    property p_ack; $rose(halt_granted) && !$past(asleep) |-> grant_ack_req;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_res; $rose(clock_halt_request_n) && halt_granted |->
        ##[3:6] core_clk_en; endproperty
    a_res: assert property (p_res) else $error("no resume");
    property p_pll; pll_run; endproperty
    a_pll: assert property (p_pll) else $error("pll off");
    property p_syn; $fell(clock_halt_request_n) && !halt_granted && !asleep
        |-> !halt_granted [*2]; endproperty
    a_syn: assert property (p_syn) else $error("unsynced");
    property p_slp; $rose(asleep) |-> $past(halt_granted); endproperty
    a_slp: assert property (p_slp) else $error("bad sleep");
    property p_dark; asleep |-> !(core_clk_en || bus_unit_clk_en); endproperty
    a_dark: assert property (p_dark) else $error("clock on");
    property p_up; $rose(sleep_request_n) && asleep |-> s_up; endproperty
    a_up: assert property (p_up) else $error("no wake");
endmodule // lpsc_chk

/* lpsc_chipset.sv */
// chipset model driving the halt and sleep request pins
module lpsc_chipset (
    input wire clk,
    input wire want_halt,
    input wire want_sleep,
    output logic clock_halt_request_n = 1'b1,
    output logic sleep_request_n = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins move 13 ns past the edge, out of step with sampling
    always @(posedge clk) begin
        clock_halt_request_n <= #13 !want_halt;
        sleep_request_n <= #13 !want_sleep;
    end
endmodule // lpsc_chipset

/* test_lpsc_ctrl.sv */
// self-checking bench for low-power state control
`define CK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
$display("unexpected %0t %h %h", $time, a, e); end end
module test_lpsc_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, resetn = 1'b0, bus_clk_present = 1'b1;
    logic want_halt = 1'b0, want_sleep = 1'b0, grant_ack_done = 1'b0;
    logic intr_req = 1'b0, snoop_req = 1'b0;
    wire clock_halt_request_n, sleep_request_n, grant_ack_req, pll_run;
    wire core_clk_en, bus_unit_clk_en, exec_en, intr_take, snoop_take;
    wire halt_granted, asleep;
    int fails = 0, checks = 0;
    always #20 clk = ~clk;
    lpsc_chipset u_cs (.clk, .want_halt, .want_sleep,
        .clock_halt_request_n, .sleep_request_n);
    lpsc_ctrl DUT (.clk, .resetn, .clock_halt_request_n, .sleep_request_n,
        .bus_clk_present, .intr_req, .snoop_req, .grant_ack_done,
        .grant_ack_req, .core_clk_en, .bus_unit_clk_en, .pll_run, .exec_en,
        .intr_take, .snoop_take, .halt_granted, .asleep);
    // settle on the falling edge so register updates have landed
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_early;
        @(posedge clk) want_sleep <= 1'b1;
        w(8);
        `CK({halt_granted, asleep, exec_en}, 3'h1)
        @(posedge clk) want_sleep <= 1'b0;
        w(8);
    endtask
    task automatic t_halt;
        @(posedge clk) want_halt <= 1'b1;
        w(8);
        `CK({halt_granted, grant_ack_req, core_clk_en, exec_en}, 4'hC)
        @(posedge clk) {intr_req, snoop_req} <= 2'h3;
        w(1);
        `CK({intr_take, snoop_take}, 2'h3)
        @(posedge clk) grant_ack_done <= 1'b1;
        @(posedge clk) grant_ack_done <= 1'b0;
        w(1);
        `CK(grant_ack_req, 1'b0)
    endtask
    task automatic t_sleep;
        @(posedge clk) want_sleep <= 1'b1;
        w(8);
        `CK({asleep, bus_unit_clk_en, intr_take, snoop_take}, 4'h8)
        @(posedge clk) want_halt <= 1'b0;
        w(8);
        `CK(asleep, 1'b1)
        @(posedge clk) want_halt <= 1'b1;
        w(8);
        @(posedge clk) want_sleep <= 1'b0;
        w(8);
        `CK({halt_granted, asleep, bus_unit_clk_en}, 3'h5)
        @(posedge clk) want_sleep <= 1'b1;
        w(8);
        // bus clock loss wakes on the next edge, long before the released
        // sleep pin clears the synchroniser; sleep may re-enter until then
        @(posedge clk) {bus_clk_present, want_sleep} <= 2'h0;
        w(1);
        `CK({halt_granted, asleep}, 2'h2)
        @(posedge clk) bus_clk_present <= 1'b1;
        w(8);
    endtask
    task automatic t_resume;
        @(posedge clk) want_halt <= 1'b0;
        w(8);
        `CK({halt_granted, core_clk_en, bus_unit_clk_en, exec_en}, 4'h7)
    endtask
    task automatic results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        w(1);
        `CK({asleep, core_clk_en, exec_en, pll_run}, 4'h7)
        t_early;
        t_halt;
        t_sleep;
        t_resume;
        results;
    end
endmodule // test_lpsc_ctrl
bind lpsc_ctrl lpsc_chk u_chk (.clk, .resetn, .clock_halt_request_n,
    .sleep_request_n, .grant_ack_req, .core_clk_en, .bus_unit_clk_en,
    .pll_run, .halt_granted, .asleep);
